// >>> hw/flash_host_pkg.sv
// Constants, types and command plans for the parallel flash host controller
package flash_host_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;
  localparam int REG_AW = 8;
  localparam int SW_DW = 32;

  // Software register offsets
  localparam logic [REG_AW-1:0] REG_CMD = 8'h00;
  localparam logic [REG_AW-1:0] REG_ADDR = 8'h04;
  localparam logic [REG_AW-1:0] REG_DATA = 8'h08;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h0c;
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h10;

  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RB_BIT = 1;
  localparam int ST_REFUSED_BIT = 2;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_WP_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;

  // Reset values of software-visible controls
  localparam logic CTRL_RESET_INIT = 1'b1;
  localparam logic CTRL_WP_INIT = 1'b0;

  // Command codes written on the data pins
  localparam logic [CODE_W-1:0] CODE_READ_ARRAY = 8'hff;
  localparam logic [CODE_W-1:0] CODE_READ_IDENT = 8'h90;
  localparam logic [CODE_W-1:0] CODE_READ_STATUS = 8'h70;
  localparam logic [CODE_W-1:0] CODE_CLEAR_STATUS = 8'h50;
  localparam logic [CODE_W-1:0] CODE_BLOCK_ERASE = 8'h20;
  localparam logic [CODE_W-1:0] CODE_CHIP_ERASE = 8'h30;
  localparam logic [CODE_W-1:0] CODE_CONFIRM = 8'hd0;
  localparam logic [CODE_W-1:0] CODE_PROGRAM = 8'h40;
  localparam logic [CODE_W-1:0] CODE_PROGRAM_ALT = 8'h10;
  localparam logic [CODE_W-1:0] CODE_LOCK_SETUP = 8'h60;
  localparam logic [CODE_W-1:0] CODE_LOCK_SET = 8'h01;
  localparam logic [CODE_W-1:0] CODE_PERM_LOCK = 8'hf1;
  localparam logic [CODE_W-1:0] CODE_OTP_PROGRAM = 8'hc0;

  // Bus timing, in ns, and derived cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETUP_NS = 20;
  localparam int T_WE_PULSE_NS = 50;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACCESS_NS = 90;
  localparam int T_RECOVER_NS = 20;
  localparam int T_SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_WE_CYC = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RECOVER_CYC =
    (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef enum logic [3:0] {
    OP_READ = 4'b0000,
    OP_MODE_ARRAY = 4'b0001,
    OP_MODE_IDENT = 4'b0010,
    OP_MODE_STATUS = 4'b0011,
    OP_CLEAR_STATUS = 4'b0100,
    OP_BLOCK_ERASE = 4'b0101,
    OP_CHIP_ERASE = 4'b0110,
    OP_PROGRAM = 4'b0111,
    OP_SUSPEND = 4'b1000,
    OP_RESUME = 4'b1001,
    OP_SET_BLOCK_LOCK = 4'b1010,
    OP_CLEAR_LOCKS = 4'b1011,
    OP_SET_PERM_LOCK = 4'b1100,
    OP_OTP_PROGRAM = 4'b1101,
    OP_PROGRAM_ALT = 4'b1110,
    OP_UNDEFINED = 4'b1111
  } op_t;

  // Bus cycles an operation needs
  typedef struct packed {
    logic valid;
    logic has_first;
    logic has_second;
    logic second_is_data;
    logic has_read;
    logic [CODE_W-1:0] first_code;
    logic [CODE_W-1:0] second_code;
  } op_plan_t;

  // Pins driven toward the flash
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } flash_pins_t;

  function automatic op_plan_t plan_one(logic [CODE_W-1:0] code, logic rd);
    op_plan_t p;
    p = '0;
    p.valid = 1'b1;
    p.has_first = 1'b1;
    p.first_code = code;
    p.has_read = rd;
    return p;
  endfunction

  function automatic op_plan_t plan_two(logic [CODE_W-1:0] code,
                                        logic [CODE_W-1:0] second,
                                        logic from_data);
    op_plan_t p;
    p = plan_one(code, 1'b0);
    p.has_second = 1'b1;
    p.second_code = second;
    p.second_is_data = from_data;
    return p;
  endfunction

  function automatic op_plan_t plan_of(op_t op, logic [CODE_W-1:0] susp);
    op_plan_t p;
    p = '0;
    case (op)
      OP_READ:
      begin
        p.valid = 1'b1;
        p.has_read = 1'b1;
      end
      OP_MODE_ARRAY: p = plan_one(CODE_READ_ARRAY, 1'b0);
      OP_MODE_IDENT: p = plan_one(CODE_READ_IDENT, 1'b1);
      OP_MODE_STATUS: p = plan_one(CODE_READ_STATUS, 1'b1);
      OP_CLEAR_STATUS: p = plan_one(CODE_CLEAR_STATUS, 1'b0);
      OP_BLOCK_ERASE: p = plan_two(CODE_BLOCK_ERASE, CODE_CONFIRM, 1'b0);
      OP_CHIP_ERASE: p = plan_two(CODE_CHIP_ERASE, CODE_CONFIRM, 1'b0);
      OP_PROGRAM: p = plan_two(CODE_PROGRAM, CODE_PROGRAM, 1'b1);
      OP_PROGRAM_ALT: p = plan_two(CODE_PROGRAM_ALT, CODE_PROGRAM_ALT, 1'b1);
      OP_SUSPEND: p = plan_one(susp, 1'b0);
      OP_RESUME: p = plan_one(CODE_CONFIRM, 1'b0);
      OP_SET_BLOCK_LOCK: p = plan_two(CODE_LOCK_SETUP, CODE_LOCK_SET, 1'b0);
      OP_CLEAR_LOCKS: p = plan_two(CODE_LOCK_SETUP, CODE_CONFIRM, 1'b0);
      OP_SET_PERM_LOCK: p = plan_two(CODE_LOCK_SETUP, CODE_PERM_LOCK, 1'b0);
      OP_OTP_PROGRAM: p = plan_two(CODE_OTP_PROGRAM, CODE_OTP_PROGRAM, 1'b1);
      default: p = '0;
    endcase
    return p;
  endfunction

endpackage

// >>> hw/flash_host.sv
// Host controller that sequences command and read cycles on a parallel flash
//
// Notes on behaviour
// - Host never holds output enable and write strobe low together.
// - Address and data latch on the first rising strobe; host holds them.
// - Host issues only defined command codes.
// - Block erase is setup code, then confirm inside the block.
// - OTP program is setup write, then address and value in OTP block.
`timescale 1ns/1ps

module flash_host #(
  // Suspend command code; arbitrary default, set to the part's value
  parameter logic [7:0] SUSPEND_CODE = 8'h00
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [flash_host_pkg::REG_AW-1:0] sw_addr,
  input wire logic [flash_host_pkg::SW_DW-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [flash_host_pkg::SW_DW-1:0] sw_rdata,
  output flash_host_pkg::flash_pins_t flash_pins,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  input wire logic ready_busy_in,
  output logic reset_powerdown_n,
  output logic write_protect_n
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_WE_LOW = 3'b010,
    S_HOLD = 3'b011,
    S_RD_ACCESS = 3'b100,
    S_RD_DONE = 3'b101
  } seq_state_t;

  localparam logic [flash_host_pkg::CNT_W-1:0] SETUP_LOAD =
    flash_host_pkg::CNT_W'(flash_host_pkg::T_SETUP_CYC - 1);
  localparam logic [flash_host_pkg::CNT_W-1:0] WE_LOAD =
    flash_host_pkg::CNT_W'(flash_host_pkg::T_WE_CYC - 1);
  localparam logic [flash_host_pkg::CNT_W-1:0] HOLD_LOAD =
    flash_host_pkg::CNT_W'(flash_host_pkg::T_HOLD_CYC - 1);
  localparam logic [flash_host_pkg::CNT_W-1:0] ACCESS_LOAD =
    flash_host_pkg::CNT_W'(flash_host_pkg::T_ACCESS_CYC - 1);
  localparam logic [flash_host_pkg::CNT_W-1:0] RECOVER_LOAD =
    flash_host_pkg::CNT_W'(flash_host_pkg::T_RECOVER_CYC - 1);

  seq_state_t state;
  seq_state_t next_state;
  logic step;
  logic next_step;
  logic [flash_host_pkg::CNT_W-1:0] cnt;
  logic [flash_host_pkg::CNT_W-1:0] next_cnt;
  flash_host_pkg::op_t op;
  flash_host_pkg::op_plan_t plan;
  logic [flash_host_pkg::ADDR_W-1:0] tgt_addr;
  logic [flash_host_pkg::DATA_W-1:0] prog_value;
  logic [flash_host_pkg::DATA_W-1:0] read_value;
  logic refused;
  logic ctrl_reset_n;
  logic ctrl_wp_n;

  // Software decode
  wire flash_host_pkg::op_t req_op =
    flash_host_pkg::op_t'(sw_wdata[flash_host_pkg::CMD_OP_LSB +:
                                   flash_host_pkg::CMD_OP_W]);
  wire flash_host_pkg::op_plan_t req_plan =
    flash_host_pkg::plan_of(req_op, SUSPEND_CODE);
  wire busy = (state != S_IDLE);
  wire cmd_wr = sw_wr && (sw_addr == flash_host_pkg::REG_CMD);
  // Undefined codes never reach the pins; nor does anything while in reset
  wire start = cmd_wr && !busy && req_plan.valid && ctrl_reset_n;
  wire refuse_set = cmd_wr && !start;
  wire refuse_clr = sw_wr && (sw_addr == flash_host_pkg::REG_CTRL) &&
                    sw_wdata[flash_host_pkg::CTRL_CLR_BIT];
  wire cnt_done = (cnt == '0);
  wire sample_now = (state == S_RD_ACCESS) && cnt_done;
  // Plan in force for the cycle being prepared
  wire flash_host_pkg::op_plan_t sel_plan = start ? req_plan : plan;

  // First cycle carries the command code, the second the confirm, lock code or value
  wire [flash_host_pkg::DATA_W-1:0] next_data =
    (next_step == 1'b0) ?
      flash_host_pkg::DATA_W'(sel_plan.first_code) :
    sel_plan.second_is_data ? prog_value :
      flash_host_pkg::DATA_W'(sel_plan.second_code);
  // Address writes are ignored while busy, so it holds through both cycles
  wire [flash_host_pkg::ADDR_W-1:0] next_addr = tgt_addr;

  wire [flash_host_pkg::SW_DW-1:0] status_word =
    flash_host_pkg::SW_DW'({refused, ready_busy_in, busy});
  wire [flash_host_pkg::SW_DW-1:0] ctrl_word =
    flash_host_pkg::SW_DW'({ctrl_wp_n, ctrl_reset_n});
  wire [flash_host_pkg::SW_DW-1:0] read_mux =
    (sw_addr == flash_host_pkg::REG_CMD) ? flash_host_pkg::SW_DW'(op) :
    (sw_addr == flash_host_pkg::REG_ADDR) ? flash_host_pkg::SW_DW'(tgt_addr) :
    (sw_addr == flash_host_pkg::REG_DATA) ?
      flash_host_pkg::SW_DW'(read_value) :
    (sw_addr == flash_host_pkg::REG_STATUS) ? status_word :
    (sw_addr == flash_host_pkg::REG_CTRL) ? ctrl_word : '0;

  // Strobes come from the next state so every pin leaves a flip-flop
  function automatic flash_host_pkg::flash_pins_t pins_for(
    seq_state_t s,
    logic [flash_host_pkg::ADDR_W-1:0] a,
    logic [flash_host_pkg::DATA_W-1:0] d
  );
    flash_host_pkg::flash_pins_t p;
    p.ce_n = (s == S_IDLE);
    p.we_n = (s != S_WE_LOW);
    // Output enable only in read states, never beside the write strobe
    p.oe_n = (s != S_RD_ACCESS);
    p.addr = a;
    p.dq_out = d;
    // Data stays driven through the hold state after the strobe rises
    p.dq_oe = (s == S_SETUP) || (s == S_WE_LOW) || (s == S_HOLD);
    return p;
  endfunction

  always_comb
  begin
    next_state = state;
    next_step = step;
    next_cnt = cnt_done ? cnt : cnt - 1'b1;
    case (state)
      S_IDLE:
      begin
        next_step = 1'b0;
        if (start && req_plan.has_first)
        begin
          next_state = S_SETUP;
          next_cnt = SETUP_LOAD;
        end
        else if (start)
        begin
          next_state = S_RD_ACCESS;
          next_cnt = ACCESS_LOAD;
        end
      end
      S_SETUP:
        if (cnt_done)
        begin
          next_state = S_WE_LOW;
          next_cnt = WE_LOAD;
        end
      S_WE_LOW:
        if (cnt_done)
        begin
          next_state = S_HOLD;
          next_cnt = HOLD_LOAD;
        end
      S_HOLD:
        if (cnt_done)
        begin
          // Two-write sequences go back to back, chip select kept low
          if (!step && plan.has_second)
          begin
            next_state = S_SETUP;
            next_step = 1'b1;
            next_cnt = SETUP_LOAD;
          end
          else if (plan.has_read)
          begin
            next_state = S_RD_ACCESS;
            next_cnt = ACCESS_LOAD;
          end
          else
            next_state = S_IDLE;
        end
      S_RD_ACCESS:
        if (cnt_done)
        begin
          next_state = S_RD_DONE;
          next_cnt = RECOVER_LOAD;
        end
      S_RD_DONE:
        if (cnt_done)
          next_state = S_IDLE;
      default:
      begin
        next_state = S_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state <= S_IDLE;
      step <= 1'b0;
      cnt <= '0;
      flash_pins <= pins_for(S_IDLE, '0, '0);
    end
    else
    begin
      state <= next_state;
      step <= next_step;
      cnt <= next_cnt;
      flash_pins <= pins_for(next_state, next_addr, next_data);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      op <= flash_host_pkg::OP_READ;
      plan <= '0;
    end
    else if (start)
    begin
      op <= req_op;
      plan <= req_plan;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      tgt_addr <= '0;
      prog_value <= '0;
    end
    else if (sw_wr && !busy)
    begin
      if (sw_addr == flash_host_pkg::REG_ADDR)
        tgt_addr <= sw_wdata[flash_host_pkg::ADDR_W-1:0];
      if (sw_addr == flash_host_pkg::REG_DATA)
        prog_value <= sw_wdata[flash_host_pkg::DATA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      read_value <= '0;
    else if (sample_now)
      read_value <= dq_in;
  end

  // A refusal in the same cycle as a clear stays recorded
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      refused <= 1'b0;
    else if (refuse_set)
      refused <= 1'b1;
    else if (refuse_clr)
      refused <= 1'b0;
  end

  // Reset and write-protect levels may change only while no cycle runs
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ctrl_reset_n <= flash_host_pkg::CTRL_RESET_INIT;
      ctrl_wp_n <= flash_host_pkg::CTRL_WP_INIT;
    end
    else if (sw_wr && !busy && (sw_addr == flash_host_pkg::REG_CTRL))
    begin
      ctrl_reset_n <= sw_wdata[flash_host_pkg::CTRL_RESET_BIT];
      ctrl_wp_n <= sw_wdata[flash_host_pkg::CTRL_WP_BIT];
    end
  end

  assign reset_powerdown_n = ctrl_reset_n;
  assign write_protect_n = ctrl_wp_n;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      sw_rdata <= '0;
    else if (sw_rd)
      sw_rdata <= read_mux;
    else
      sw_rdata <= '0;
  end

endmodule

// >>> tb/flash_host_properties.sv
// Port assertions for the flash host controller
`timescale 1ns/1ps
module flash_host_properties (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic sw_rd,
  input wire logic [flash_host_pkg::SW_DW-1:0] sw_rdata,
  input wire flash_host_pkg::flash_pins_t flash_pins,
  input wire logic reset_powerdown_n
);
  wire logic ce_n = flash_pins.ce_n;
  wire logic oe_n = flash_pins.oe_n;
  wire logic we_n = flash_pins.we_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence we_low;
    (!we_n) [*5] ##1 we_n;
  endsequence
  sequence oe_low;
    (!oe_n) [*8] ##1 !oe_n ##1 oe_n;
  endsequence
  a_strobe_excl: assert property (oe_n || we_n)
    else $error("oe_n and we_n low together");
  a_we_width: assert property ($fell(we_n) |-> we_low)
    else $error("write strobe width wrong");
  a_we_setup: assert property ($fell(we_n) |->
    $past(flash_pins.dq_oe, 2) && !ce_n && $stable(flash_pins.addr))
    else $error("write setup not held");
  a_we_hold: assert property ($rose(we_n) |-> !ce_n &&
    flash_pins.dq_oe && $stable(flash_pins.dq_out)
    && $stable(flash_pins.addr))
    else $error("write data changed at latch edge");
  a_read_width: assert property ($fell(oe_n) |-> oe_low)
    else $error("read strobe width wrong");
  a_read_free: assert property (!oe_n |-> !ce_n && !flash_pins.dq_oe)
    else $error("host drives data during read");
  a_rdata_slot: assert property (sw_rdata != '0 |-> $past(sw_rd))
    else $error("read data outside its slot");
  a_rp_quiet: assert property (!reset_powerdown_n |->
    ce_n && oe_n && we_n)
    else $error("bus cycle while device in reset");
endmodule
bind flash_host flash_host_properties chk_u (.ref_clk(ref_clk),
  .rstn(rstn), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
  .flash_pins(flash_pins), .reset_powerdown_n(reset_powerdown_n));

// >>> tb/flash_dev_model.sv
// Behavioural model of the parallel flash device
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER = 16'h0011, // Arbitrary value
  parameter logic [15:0] PART = 16'h0022, // Arbitrary value
  parameter logic [7:0] SUSP = 8'h00, // Arbitrary value
  parameter int BUSY_NS = 3000
) (
  input wire flash_host_pkg::flash_pins_t pins,
  input wire logic rp_n,
  input wire logic wp_n,
  input wire logic supply_ok,
  output logic [15:0] dq,
  output logic rb_low
);
  logic [15:0] mem [logic [18:0]];
  logic [127:0] lk = '0;
  logic [1:0] mode = 2'd0;
  logic [7:0] pend = 8'h00;
  logic busy = 1'b0;
  logic plock = 1'b0;
  logic susp = 1'b0;
  logic [15:0] rv;
  logic [15:0] last = 16'h0000;
  logic [7:0] d;
  wire logic [6:0] blk = pins.addr[18:12];
  wire logic ok = supply_ok && !busy;
  wire logic drv = rp_n && !pins.ce_n && !pins.oe_n && pins.we_n;
  initial mem[19'h0_0005] = 16'h1234;
  // Both boot blocks follow the protect pin as well as their lock bits
  function automatic logic locked(input logic [6:0] b);
    return lk[b] || (!wp_n && b < 7'd2);
  endfunction
  task automatic go();
    busy = 1'b1;
    mode = 2'd2;
    fork
      begin
        #BUSY_NS;
        busy = 1'b0;
        susp = 1'b0;
      end
    join_none
  endtask
  always @(posedge pins.we_n or negedge rp_n)
    if (!rp_n)
    begin
      mode = 2'd0;
      pend = 8'h00;
      busy = 1'b0;
      susp = 1'b0;
    end
    else if (!pins.ce_n)
    begin
      d = pins.dq_out[7:0];
      case (pend)
        8'h40, 8'h10, 8'hc0:
        begin
          if (ok && !locked(blk)) mem[pins.addr] = pins.dq_out;
          go();
        end
        8'h20:
          if (d == 8'hd0 && ok && !locked(blk))
          begin
            foreach (mem[k])
              if (k[18:12] == blk) mem[k] = 16'hffff;
            go();
          end
        8'h30:
          if (d == 8'hd0 && ok)
          begin
            foreach (mem[k])
              if (!locked(k[18:12])) mem[k] = 16'hffff;
            go();
          end
        8'h60:
          if (ok && !plock)
          begin
            if (d == 8'h01) lk[blk] = 1'b1;
            if (d == 8'hd0) lk = '0;
            if (d == 8'hf1) plock = 1'b1;
            go();
          end
        default:
          if (d == 8'hff && (!busy || susp)) mode = 2'd0;
          else if (d == 8'h90) mode = 2'd1;
          else if (d == 8'h70) mode = 2'd2;
          else if (d == SUSP && busy) susp = 1'b1;
          else if (d == 8'hd0 && susp) susp = 1'b0;
      endcase
      pend = (pend == 8'h00 &&
        d inside {8'h40, 8'h10, 8'hc0, 8'h20, 8'h30, 8'h60}) ? d : 8'h00;
    end
  always @*
    case (mode)
      2'd1: rv = pins.addr == 19'h0 ? MAKER : pins.addr == 19'h1 ? PART :
        {15'h0, pins.addr == 19'h3 ? plock : lk[blk]};
      2'd2: rv = {8'h00, !busy, 7'h00};
      default: rv = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
    endcase
  always @(rv or drv)
    if (drv) last = rv;
  // A released bus must not keep showing the last word
  assign dq = drv ? rv : ~last;
  assign rb_low = busy && !susp && rp_n;
endmodule

// >>> tb/tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic supply_ok = 1'b1;
  logic [31:0] sw_rdata, s;
  flash_host_pkg::flash_pins_t pins;
  logic [15:0] dq;
  logic rb_low, rp_n, wp_n;
  int error_cnt = 0;
  int samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  flash_host dut_u (.ref_clk(ref_clk), .rstn(rstn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .flash_pins(pins), .dq_in(dq), .ready_busy_in(~rb_low),
    .reset_powerdown_n(rp_n), .write_protect_n(wp_n));
  flash_dev_model dev_u (.pins(pins), .rp_n(rp_n), .wp_n(wp_n),
    .supply_ok(supply_ok), .dq(dq), .rb_low(rb_low));
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    @(posedge ref_clk);
    v = sw_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Poll one status bit until it shows the wanted level
  task automatic poll(input int b, input logic lvl);
    s = {32{~lvl}};
    for (int i = 0; i < 500 && s[b] !== lvl; i++)
      rd(flash_host_pkg::REG_STATUS, s);
    // A poll that runs out is a mismatch
    if (s[b] !== lvl) chk({31'h0, s[b]}, {31'h0, lvl});
  endtask
  task automatic run(input logic [18:0] a, input logic [3:0] o);
    wr(flash_host_pkg::REG_ADDR, {13'h0, a});
    wr(flash_host_pkg::REG_CMD, {28'h0, o});
    poll(0, 1'b0);
  endtask
  task automatic rdv(input logic [18:0] a, input logic [3:0] o,
                     input logic [15:0] exp);
    logic [31:0] v;
    run(a, o);
    rd(flash_host_pkg::REG_DATA, v);
    chk(v, {16'h0, exp});
  endtask
  task automatic prog(input logic [18:0] a, input logic [3:0] o,
                      input logic [15:0] v, input logic [15:0] exp);
    wr(flash_host_pkg::REG_DATA, {16'h0, v});
    run(a, o);
    poll(1, 1'b1);
    run(a, 4'd1);
    rdv(a, 4'd0, exp);
  endtask
  task automatic t_modes();
    rd(flash_host_pkg::REG_CTRL, s);
    chk(s & 32'h3, 32'h1);
    rd(8'h14, s);
    chk(s, 32'h0);
    rdv(19'h5, 4'd0, 16'h1234);
    rdv(19'h0, 4'd2, 16'h0011);
    rdv(19'h1, 4'd0, 16'h0022);
    run(19'h7, 4'd1);
    rdv(19'h5, 4'd0, 16'h1234);
    $display("t_modes done");
  endtask
  task automatic t_program();
    wr(flash_host_pkg::REG_CTRL, 32'h3);
    wr(flash_host_pkg::REG_DATA, 32'h5a5a);
    run(19'h2_0010, 4'd7);
    chk({31'h0, s[1]}, 32'h0);
    run(19'h2_0010, 4'd1);
    rdv(19'h2_0010, 4'd0, 16'h0000);
    poll(1, 1'b1);
    rdv(19'h2_0010, 4'd3, 16'h0080);
    run(19'h2_0010, 4'd1);
    rdv(19'h2_0010, 4'd0, 16'h5a5a);
    prog(19'h2_0011, 4'd14, 16'hc3c3, 16'hc3c3);
    prog(19'h0_0090, 4'd13, 16'h0f0f, 16'h0f0f);
    wr(flash_host_pkg::REG_DATA, 32'h7777);
    run(19'h2_0020, 4'd7);
    run(19'h2_0020, 4'd8);
    chk({31'h0, s[1]}, 32'h1);
    run(19'h2_0020, 4'd1);
    rdv(19'h2_0010, 4'd0, 16'h5a5a);
    run(19'h2_0020, 4'd9);
    chk({31'h0, s[1]}, 32'h0);
    poll(1, 1'b1);
    $display("t_program done");
  endtask
  task automatic t_protect();
    wr(flash_host_pkg::REG_CTRL, 32'h1);
    prog(19'h0_0100, 4'd7, 16'h1111, 16'hffff);
    wr(flash_host_pkg::REG_CTRL, 32'h3);
    prog(19'h0_0100, 4'd7, 16'h1111, 16'h1111);
    prog(19'h2_2000, 4'd10, 16'h0, 16'hffff);
    prog(19'h2_2004, 4'd7, 16'h2222, 16'hffff);
    prog(19'h0_0000, 4'd11, 16'h0, 16'hffff);
    prog(19'h2_2004, 4'd7, 16'h2222, 16'h2222);
    prog(19'h0_0000, 4'd12, 16'h0, 16'hffff);
    prog(19'h2_2000, 4'd10, 16'h0, 16'hffff);
    prog(19'h2_2008, 4'd7, 16'h3333, 16'h3333);
    rdv(19'h3, 4'd2, 16'h0001);
    supply_ok <= 1'b0;
    prog(19'h2_2008, 4'd7, 16'h4444, 16'h3333);
    supply_ok <= 1'b1;
    prog(19'h2_2004, 4'd5, 16'h0, 16'hffff);
    prog(19'h7_1234, 4'd6, 16'h0, 16'hffff);
    rdv(19'h2_0010, 4'd0, 16'hffff);
    $display("t_protect done");
  endtask
  task automatic t_refuse();
    run(19'h0, 4'd15);
    rd(flash_host_pkg::REG_STATUS, s);
    chk(s & 32'h4, 32'h4);
    wr(flash_host_pkg::REG_CTRL, 32'h7);
    rd(flash_host_pkg::REG_STATUS, s);
    chk(s & 32'h4, 32'h0);
    rdv(19'h0, 4'd2, 16'h0011);
    wr(flash_host_pkg::REG_CTRL, 32'h2);
    run(19'h0, 4'd1);
    rd(flash_host_pkg::REG_STATUS, s);
    chk(s & 32'h4, 32'h4);
    wr(flash_host_pkg::REG_CTRL, 32'h7);
    rdv(19'h0, 4'd0, 16'hffff);
    $display("t_refuse done");
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_modes();
    t_program();
    t_protect();
    t_refuse();
    end_sim();
  end
  // Whole run needs well under this many cycles
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    end_sim();
  end
endmodule
